//--- rtl/mtrm_map.sv
/*
 * holds the memory type range map: capability, default type control, eleven sub-megabyte range registers,
 * the register access port and the per-address type lookup.
 * assumes register requests and lookups come from logic on the same clock, and that the variable-range
 * matcher outside supplies its hit and type in the same cycle as the lookup address.
 */
`include "mtrm_defs.svh"

module mtrm_map #(
  parameter int                 PA_W         = 36,
  parameter logic [7:0]         VAR_COUNT    = 8'h08,
  parameter bit                 FIX_PRESENT  = 1'b1,
  parameter bit                 WC_PRESENT   = 1'b1,
  parameter bit                 SMM_PRESENT  = 1'b0
) (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic                     msr_valid,
  input  wire logic                     msr_write,
  input  wire logic [`MTRM_IDX_W-1:0]   msr_index,
  input  wire mtrm_pkg::mtrm_word_t     msr_wdata,
  output      mtrm_pkg::mtrm_word_t     msr_rdata_q,
  output      logic                     msr_done_q,
  output      logic                     protection_fault_q,
  output      logic [31:0]              ident_feature_q,
  input  wire logic                     lookup_valid,
  input  wire logic [PA_W-1:0]          lookup_addr,
  input  wire logic                     var_hit,
  input  wire mtrm_pkg::mtrm_kind_t     var_kind,
  output      logic                     kind_valid_q,
  output      mtrm_pkg::mtrm_kind_t     kind_q
);

  // ************************************************************
  // type legality
  // ************************************************************
  // write-combining is refused when the part does not offer it
  function automatic logic mtrm_legal(input mtrm_pkg::mtrm_kind_t t);
    logic ok;
    ok = (t == `MTRM_T_UC) || (t == `MTRM_T_WT) || (t == `MTRM_T_WP) || (t == `MTRM_T_WB)
      || ((t == `MTRM_T_WC) && WC_PRESENT);
    return ok;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  mtrm_pkg::mtrm_word_t cap_word;
  mtrm_pkg::mtrm_word_t def_q;
  mtrm_pkg::mtrm_word_t fix_q [`MTRM_FIX_COUNT];
  logic [`MTRM_BYTES-1:0] wbyte_ok;
  logic                   wr_cap;
  logic                   wr_def;
  logic                   wr_fix;
  logic                   is_fix;
  logic                   def_ok;
  logic                   wr_ok;
  logic [`MTRM_FIX_SEL_W-1:0] wsel;
  logic [`MTRM_FIX_COUNT*`MTRM_BYTES*`MTRM_BYTE_W-1:0] fix_flat;

  // flat copy so a refused write can be checked against every range register at once
  for (genvar gf = 0; gf < `MTRM_FIX_COUNT; gf++) begin : g_fix_flat
    assign fix_flat[gf*`MTRM_BYTES*`MTRM_BYTE_W +: `MTRM_BYTES*`MTRM_BYTE_W] = fix_q[gf];
  end

  // reserved capability bits stay zero
  always_comb begin
    cap_word = `MTRM_RST_REG;
    cap_word[`MTRM_TYPE_HI:`MTRM_TYPE_LO] = VAR_COUNT;
    cap_word[`MTRM_CAP_FIX_BIT] = FIX_PRESENT;
    cap_word[`MTRM_CAP_WC_BIT]  = WC_PRESENT;
    cap_word[`MTRM_CAP_SMM_BIT] = SMM_PRESENT;
  end

  // ************************************************************
  // request decode
  // ************************************************************
  assign is_fix = FIX_PRESENT && (msr_index >= `MTRM_IDX_FIX0) && (msr_index <= `MTRM_IDX_FIX_LAST);
  assign wsel   = msr_index - `MTRM_IDX_FIX0;
  assign wr_cap = msr_valid && msr_write && (msr_index == `MTRM_IDX_CAP);
  assign wr_def = msr_valid && msr_write && (msr_index == `MTRM_IDX_DEF);
  assign wr_fix = msr_valid && msr_write && is_fix;

  genvar gb;
  generate
    for (gb = 0; gb < `MTRM_BYTES; gb++) begin : g_byte_chk
      assign wbyte_ok[gb] = mtrm_legal(msr_wdata[gb*`MTRM_BYTE_W +: `MTRM_BYTE_W]);
    end
  endgenerate

  assign def_ok = mtrm_legal(msr_wdata[`MTRM_TYPE_HI:`MTRM_TYPE_LO])
               && ((msr_wdata & `MTRM_DEF_RSV_LO_M) == `MTRM_RST_REG);
  assign wr_ok  = (wr_def && def_ok) || (wr_fix && (&wbyte_ok));

  // ************************************************************
  // control register
  // ************************************************************
  // a refused write leaves the old value intact
  always_ff @(posedge clock) begin
    if (srst) begin
      def_q <= `MTRM_RST_REG;
    end else if (wr_def && def_ok) begin
      def_q <= msr_wdata;
    end
  end

  // ************************************************************
  // sub-megabyte range registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < `MTRM_FIX_COUNT; i++) begin
        fix_q[i] <= `MTRM_RST_REG;
      end
    end else if (wr_fix && (&wbyte_ok)) begin
      fix_q[wsel] <= msr_wdata;
    end
  end

  // ************************************************************
  // register port answer
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      msr_done_q         <= 1'b0;
      protection_fault_q <= 1'b0;
      msr_rdata_q        <= `MTRM_RST_REG;
    end else begin
      msr_done_q         <= msr_valid;
      protection_fault_q <= 1'b0;
      msr_rdata_q        <= `MTRM_RST_REG;
      if (msr_valid && msr_write) begin
        protection_fault_q <= wr_cap || !wr_ok;
      end else if (msr_valid) begin
        if (msr_index == `MTRM_IDX_CAP) begin
          msr_rdata_q <= cap_word;
        end else if (msr_index == `MTRM_IDX_DEF) begin
          msr_rdata_q <= def_q;
        end else if (is_fix) begin
          msr_rdata_q <= fix_q[wsel];
        end else begin
          protection_fault_q <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // identification query
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      ident_feature_q <= `MTRM_RST_IDENT;
    end else begin
      ident_feature_q <= `MTRM_RST_IDENT;
      ident_feature_q[`MTRM_IDENT_BIT] <= 1'b1;
    end
  end

  // ************************************************************
  // sub-megabyte type select
  // ************************************************************
  logic [`MTRM_FIX_SEL_W-1:0] lsel;
  logic [2:0]                 lbyte;
  logic                       low_mb;
  mtrm_pkg::mtrm_word_t       lword;
  mtrm_pkg::mtrm_kind_t       fix_kind;

  assign low_mb = (lookup_addr[PA_W-1:`MTRM_MB_BIT] == '0);

  always_comb begin
    lsel  = '0;
    lbyte = '0;
    if (!lookup_addr[`MTRM_A19]) begin
      lbyte = lookup_addr[`MTRM_B64_HI:`MTRM_B64_LO];
    end else if (!lookup_addr[`MTRM_A18]) begin
      lsel  = `MTRM_SEL_16K + {3'h0, lookup_addr[`MTRM_B16_REG]};
      lbyte = lookup_addr[`MTRM_B16_HI:`MTRM_B16_LO];
    end else begin
      lsel  = `MTRM_SEL_4K + {1'b0, lookup_addr[`MTRM_B4_REG_HI:`MTRM_B4_REG_LO]};
      lbyte = lookup_addr[`MTRM_B4_HI:`MTRM_B4_LO];
    end
  end

  assign lword    = fix_q[lsel];
  assign fix_kind = lword[{lbyte, 3'h0} +: `MTRM_BYTE_W];

  // ************************************************************
  // type lookup
  // ************************************************************
  // registered so the answer always lands one clock after the address
  always_ff @(posedge clock) begin
    if (srst) begin
      kind_valid_q <= 1'b0;
      kind_q       <= `MTRM_T_UC;
    end else begin
      kind_valid_q <= lookup_valid;
      if (!def_q[`MTRM_DEF_ON_BIT]) begin
        kind_q <= `MTRM_T_UC;
      end else if (FIX_PRESENT && def_q[`MTRM_DEF_SUB_BIT] && low_mb) begin
        kind_q <= fix_kind;
      end else if (var_hit) begin
        kind_q <= var_kind;
      end else begin
        kind_q <= def_q[`MTRM_TYPE_HI:`MTRM_TYPE_LO];
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_wr_req(logic [`MTRM_IDX_W-1:0] idx);
    msr_valid && msr_write && (msr_index == idx);
  endsequence

  sequence s_faulted;
    msr_done_q && protection_fault_q;
  endsequence

  a_cap_write_fault: assert property (@(posedge clock) disable iff (srst)
    s_wr_req(`MTRM_IDX_CAP) |=> s_faulted)
    else $error("capability write did not fault");

  a_def_bad_type: assert property (@(posedge clock) disable iff (srst)
    s_wr_req(`MTRM_IDX_DEF) ##0 !mtrm_legal(msr_wdata[`MTRM_TYPE_HI:`MTRM_TYPE_LO]) |=> s_faulted ##0 $stable(def_q))
    else $error("illegal default type accepted");

  a_def_rsvd_bits: assert property (@(posedge clock) disable iff (srst)
    s_wr_req(`MTRM_IDX_DEF) ##0 ((msr_wdata & `MTRM_DEF_RSV_LO_M) != `MTRM_RST_REG) |=> s_faulted ##0 $stable(def_q))
    else $error("reserved control bits accepted");

  a_fix_bad_type: assert property (@(posedge clock) disable iff (srst)
    wr_fix && !(&wbyte_ok) |=> s_faulted ##0 $stable(fix_flat))
    else $error("reserved range type accepted");

  a_global_off_uc: assert property (@(posedge clock) disable iff (srst)
    lookup_valid && !def_q[`MTRM_DEF_ON_BIT] |=> kind_valid_q && (kind_q == `MTRM_T_UC))
    else $error("disabled map gave a cached type");

  a_fixed_wins: assert property (@(posedge clock) disable iff (srst)
    lookup_valid && def_q[`MTRM_DEF_ON_BIT] && def_q[`MTRM_DEF_SUB_BIT] && low_mb && var_hit
    |=> kind_q == $past(fix_kind))
    else $error("variable range overrode sub-megabyte type");

  a_fixed_off_var: assert property (@(posedge clock) disable iff (srst)
    lookup_valid && def_q[`MTRM_DEF_ON_BIT] && !def_q[`MTRM_DEF_SUB_BIT] && var_hit
    |=> kind_q == $past(var_kind))
    else $error("variable range ignored below one megabyte");

  a_default_kind: assert property (@(posedge clock) disable iff (srst)
    lookup_valid && def_q[`MTRM_DEF_ON_BIT] && !var_hit && !(def_q[`MTRM_DEF_SUB_BIT] && low_mb)
    |=> kind_q == $past(def_q[`MTRM_TYPE_HI:`MTRM_TYPE_LO]))
    else $error("default type not applied");

  a_cap_readback: assert property (@(posedge clock) disable iff (srst)
    msr_valid && !msr_write && (msr_index == `MTRM_IDX_CAP)
    |=> !protection_fault_q && (msr_rdata_q == {52'h0, SMM_PRESENT, WC_PRESENT, 1'b0, FIX_PRESENT, VAR_COUNT}))
    else $error("capability read wrong");

  a_reset_off: assert property (@(posedge clock)
    srst |=> (def_q == `MTRM_RST_REG) && (kind_q == `MTRM_T_UC))
    else $error("reset left map enabled");

  a_def_writeback: assert property (@(posedge clock) disable iff (srst)
    wr_def && def_ok ##1 msr_valid && !msr_write && (msr_index == `MTRM_IDX_DEF)
    |=> msr_rdata_q == $past(msr_wdata, 2))
    else $error("control register did not read back");

endmodule

//--- shared/mtrm_defs.svh
/*
 * holds the register indices, field positions, type codes and reset values of the memory type range map.
 * assumes it is included by bare name, once per compilation unit, before the package and the map module.
 */
`ifndef MTRM_DEFS_SVH
`define MTRM_DEFS_SVH

// ************************************************************
// register indices on the model-specific register port
// ************************************************************
`define MTRM_IDX_W        4
`define MTRM_IDX_CAP      4'h0
`define MTRM_IDX_DEF      4'h1
`define MTRM_IDX_FIX0     4'h2
`define MTRM_IDX_FIX_LAST 4'hc
`define MTRM_FIX_COUNT    11
`define MTRM_FIX_SEL_W    4

// ************************************************************
// field positions
// ************************************************************
`define MTRM_TYPE_HI      7
`define MTRM_TYPE_LO      0
`define MTRM_CAP_FIX_BIT  8
`define MTRM_CAP_WC_BIT   10
`define MTRM_CAP_SMM_BIT  11
`define MTRM_DEF_RSV_LO_M 64'hffff_ffff_ffff_f300
`define MTRM_DEF_SUB_BIT  10
`define MTRM_DEF_ON_BIT   11
`define MTRM_IDENT_BIT    12
`define MTRM_BYTES        8
`define MTRM_BYTE_W       8

// ************************************************************
// address map below one megabyte
// ************************************************************
`define MTRM_MB_BIT       20
`define MTRM_A19          19
`define MTRM_A18          18
`define MTRM_B64_HI       18
`define MTRM_B64_LO       16
`define MTRM_B16_REG      17
`define MTRM_B16_HI       16
`define MTRM_B16_LO       14
`define MTRM_B4_REG_HI    17
`define MTRM_B4_REG_LO    15
`define MTRM_B4_HI        14
`define MTRM_B4_LO        12
`define MTRM_SEL_16K      4'h1
`define MTRM_SEL_4K       4'h3

// ************************************************************
// memory type codes and reset values
// ************************************************************
`define MTRM_T_UC         8'h00
`define MTRM_T_WC         8'h01
`define MTRM_T_WT         8'h04
`define MTRM_T_WP         8'h05
`define MTRM_T_WB         8'h06
`define MTRM_RST_REG      64'h0000_0000_0000_0000
`define MTRM_RST_IDENT    32'h0000_0000

`endif

//--- shared/mtrm_pkg.sv
/*
 * holds the shared types of the memory type range map.
 * assumes nothing beyond a compiler that reads packages before modules.
 */
package mtrm_pkg;
  typedef logic [7:0]  mtrm_kind_t;
  typedef logic [63:0] mtrm_word_t;
endpackage

//--- tb/mtrm_map_tb.sv
/*
 * holds the self-checking bench of the memory type range map: register port tasks, lookup task, tests.
 * assumes the map module with its default capability parameters and a 36-bit physical address.
 */
`include "mtrm_defs.svh"

module mtrm_map_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clock = 1'b0;
  logic                   srst = 1'b1;
  logic                   msr_valid = 1'b0;
  logic                   msr_write = 1'b0;
  logic [3:0]             msr_index = 4'h0;
  mtrm_pkg::mtrm_word_t   msr_wdata = 64'h0;
  mtrm_pkg::mtrm_word_t   msr_rdata_q;
  logic                   msr_done_q;
  logic                   protection_fault_q;
  logic [31:0]            ident_feature_q;
  logic                   lookup_valid = 1'b0;
  logic [35:0]            lookup_addr = 36'h0;
  logic                   var_hit = 1'b0;
  mtrm_pkg::mtrm_kind_t   var_kind = 8'h00;
  logic                   kind_valid_q;
  mtrm_pkg::mtrm_kind_t   kind_q;
  int                     n_errors = 0;
  int                     checks_done = 0;
  int                     cycles = 0;
  mtrm_pkg::mtrm_kind_t   legal [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  mtrm_pkg::mtrm_kind_t   bad [4] = '{8'h02, 8'h03, 8'h07, 8'hff};
  int                     rsv_bit [4] = '{8, 9, 12, 63};

  mtrm_map i_mtrm_map (
    .clock              (clock),
    .srst               (srst),
    .msr_valid          (msr_valid),
    .msr_write          (msr_write),
    .msr_index          (msr_index),
    .msr_wdata          (msr_wdata),
    .msr_rdata_q        (msr_rdata_q),
    .msr_done_q         (msr_done_q),
    .protection_fault_q (protection_fault_q),
    .ident_feature_q    (ident_feature_q),
    .lookup_valid       (lookup_valid),
    .lookup_addr        (lookup_addr),
    .var_hit            (var_hit),
    .var_kind           (var_kind),
    .kind_valid_q       (kind_valid_q),
    .kind_q             (kind_q)
  );

  always #20 clock = ~clock;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ceiling well above the roughly 320 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one request, then one idle cycle; done, fault and data stand one cycle only
  task automatic msr(input logic wr, input logic [3:0] idx, input mtrm_pkg::mtrm_word_t wd,
                     input logic exp_f, input mtrm_pkg::mtrm_word_t exp_rd, input string nm);
    @(negedge clock);
    msr_valid = 1'b1;
    msr_write = wr;
    msr_index = idx;
    msr_wdata = wd;
    @(negedge clock);
    chk({nm, " done"}, {63'h0, msr_done_q}, 64'h1);
    chk({nm, " fault"}, {63'h0, protection_fault_q}, {63'h0, exp_f});
    chk({nm, " rdata"}, msr_rdata_q, exp_rd);
    msr_valid = 1'b0;
    msr_write = 1'b0;
  endtask

  task automatic look(input logic [35:0] a, input logic hit, input mtrm_pkg::mtrm_kind_t vk,
                      input mtrm_pkg::mtrm_kind_t exp);
    @(negedge clock);
    lookup_valid = 1'b1;
    lookup_addr = a;
    var_hit = hit;
    var_kind = vk;
    @(negedge clock);
    chk("kind valid", {63'h0, kind_valid_q}, 64'h1);
    chk("kind", {56'h0, kind_q}, {56'h0, exp});
    lookup_valid = 1'b0;
  endtask

  function automatic mtrm_pkg::mtrm_word_t fixval(input int i);
    mtrm_pkg::mtrm_word_t v;
    for (int k = 0; k < 8; k++) begin
      v[8*k +: 8] = legal[(i + k) % 5];
    end
    return v;
  endfunction

  // top selects the last byte of the sub-range, base selects the first
  function automatic logic [35:0] fixaddr(input int i, input int k, input bit top);
    logic [35:0] base;
    logic [35:0] size;
    if (i == 0) begin
      size = 36'h10000;
      base = 36'h0;
    end else if (i < 3) begin
      size = 36'h4000;
      base = 36'h80000 + 36'(i - 1) * 36'h20000;
    end else begin
      size = 36'h1000;
      base = 36'hc0000 + 36'(i - 3) * 36'h8000;
    end
    return base + 36'(k) * size + (top ? size - 36'h1 : 36'h0);
  endfunction

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (10) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    chk("ident", {32'h0, ident_feature_q}, 64'h1000);
    msr(1'b0, 4'h1, 64'h0, 1'b0, 64'h0, "control at reset");
    look(36'h0_000c_0000, 1'b1, 8'h06, 8'h00);
    $display("test reset done");

    msr(1'b0, 4'h0, 64'h0, 1'b0, 64'h0000_0000_0000_0508, "capability");
    msr(1'b1, 4'h0, 64'h0, 1'b1, 64'h0, "capability write");
    msr(1'b0, 4'h0, 64'h0, 1'b0, 64'h0000_0000_0000_0508, "capability kept");
    $display("test capability done");

    for (int t = 0; t < 5; t++) begin
      msr(1'b1, 4'h1, {56'h8, legal[t]}, 1'b0, 64'h0, "control write");
      msr(1'b0, 4'h1, 64'h0, 1'b0, {56'h8, legal[t]}, "control read");
    end
    for (int t = 0; t < 4; t++) begin
      msr(1'b1, 4'h1, {56'h8, bad[t]}, 1'b1, 64'h0, "bad default");
      msr(1'b1, 4'h1, 64'h806 | (64'h1 << rsv_bit[t]), 1'b1, 64'h0, "reserved bit");
    end
    msr(1'b0, 4'h1, 64'h0, 1'b0, 64'h806, "control kept");
    $display("test control done");

    for (int i = 0; i < 11; i++) begin
      msr(1'b1, 4'(i + 2), fixval(i), 1'b0, 64'h0, "sub write");
      msr(1'b0, 4'(i + 2), 64'h0, 1'b0, fixval(i), "sub read");
    end
    for (int t = 0; t < 4; t++) begin
      msr(1'b1, 4'h5, fixval(0) ^ {56'h0, bad[t] ^ legal[0]} << 40, 1'b1, 64'h0, "bad sub");
    end
    msr(1'b0, 4'h5, 64'h0, 1'b0, fixval(3), "sub kept");
    msr(1'b0, 4'hd, 64'h0, 1'b1, 64'h0, "unmapped read");
    msr(1'b1, 4'hf, 64'h0, 1'b1, 64'h0, "unmapped write");
    $display("test sub registers done");

    // sub-range enable without global enable must stay uncached
    msr(1'b1, 4'h1, 64'h406, 1'b0, 64'h0, "global off");
    look(fixaddr(0, 3, 1'b0), 1'b1, 8'h05, 8'h00);
    look(36'h1_0000_0000, 1'b0, 8'h00, 8'h00);
    msr(1'b1, 4'h1, 64'hc06, 1'b0, 64'h0, "all on");
    for (int i = 0; i < 11; i++) begin
      for (int k = 0; k < 8; k++) begin
        look(fixaddr(i, k, k[0]), 1'b1, 8'h05, legal[(i + k) % 5]);
      end
    end
    look(36'h0_0010_0000, 1'b1, 8'h04, 8'h04);
    look(36'h0_0010_0000, 1'b0, 8'h04, 8'h06);
    $display("test lookup enabled done");

    // write then read with no gap: the read must already see the new value
    @(negedge clock);
    msr_valid = 1'b1;
    msr_write = 1'b1;
    msr_index = 4'h1;
    msr_wdata = 64'h805;
    @(negedge clock);
    chk("sub off write done", {63'h0, msr_done_q}, 64'h1);
    chk("sub off fault", {63'h0, protection_fault_q}, 64'h0);
    msr_write = 1'b0;
    @(negedge clock);
    chk("sub off read done", {63'h0, msr_done_q}, 64'h1);
    chk("sub off rdata", msr_rdata_q, 64'h805);
    msr_valid = 1'b0;
    look(fixaddr(2, 5, 1'b0), 1'b1, 8'h01, 8'h01);
    look(fixaddr(10, 7, 1'b1), 1'b0, 8'h01, 8'h05);
    $display("test lookup sub off done");

    // absent memory above the populated area falls to an uncached default
    msr(1'b1, 4'h1, 64'h800, 1'b0, 64'h0, "uncached default");
    look(36'h8_0000_0000, 1'b0, 8'h06, 8'h00);

    // reset in mid-run must clear what software configured
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    msr(1'b0, 4'h1, 64'h0, 1'b0, 64'h0, "control after reset");
    chk("ident after reset", {32'h0, ident_feature_q}, 64'h1000);
    msr(1'b0, 4'h2, 64'h0, 1'b0, 64'h0, "sub after reset");
    look(fixaddr(0, 1, 1'b0), 1'b1, 8'h06, 8'h00);
    $display("test mid reset done");
    end_of_test();
  end
endmodule
